// *** rtl/pll_div_pkg.sv ***
// Shared constants for the clock multiplier divider configuration block.
package pll_div_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Divider widths and ratio offsets.
  localparam int unsigned LS_W         = 20;
  localparam int unsigned HS_W         = 3;
  // A high-speed code of zero divides by four, so the terminal count is code plus three.
  localparam int unsigned HS_TERM_MIN  = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets on the serial control port.
  localparam logic [7:0] ADDR_OUT1_MID = 8'h20;
  localparam logic [7:0] ADDR_OUT1_LOW = 8'h21;
  localparam logic [7:0] ADDR_OUT2_HIGH = 8'h22;
  localparam logic [7:0] ADDR_OUT2_MID = 8'h23;
  localparam logic [7:0] ADDR_OUT2_LOW = 8'h24;
  localparam logic [7:0] ADDR_FB_HIGH  = 8'h28;
  localparam logic [7:0] ADDR_FB_MID   = 8'h29;
  localparam logic [7:0] ADDR_FB_LOW   = 8'h2A;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [7:0] RST_OUT1_MID  = 8'h00;
  localparam logic [7:0] RST_OUT1_LOW  = 8'h31;
  localparam logic [7:0] RST_OUT2_HIGH = 8'h00;
  localparam logic [7:0] RST_OUT2_MID  = 8'h00;
  localparam logic [7:0] RST_OUT2_LOW  = 8'h31;
  localparam logic [7:0] RST_FB_HIGH   = 8'hC0;
  localparam logic [7:0] RST_FB_MID    = 8'h00;
  localparam logic [7:0] RST_FB_LOW    = 8'hF9;
  localparam logic [7:0] RD_NONE       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions inside the upper registers.
  localparam int unsigned FB_HS_MSB    = 7;
  localparam int unsigned FB_HS_LSB    = 5;
  localparam int unsigned LS_TOP_MSB   = 3;

endpackage

// *** rtl/div_stage_if.sv ***
// Connection between the configuration top and one divider stage.
`timescale 1ns/1ns
`default_nettype none

interface div_stage_if #(parameter int unsigned W = 20);
  logic [W-1:0] value;
  logic         tick_in;
  logic         tick_out;

  // The stage counts input ticks and returns its divided tick.
  modport stage (input value, input tick_in, output tick_out);
  // The top supplies the ratio setting and the source ticks.
  modport feed  (output value, output tick_in, input tick_out);
endinterface

`default_nettype wire

// *** rtl/hs_divider.sv ***
// High-speed divider stage that divides input ticks by its code plus four.
`timescale 1ns/1ns
`default_nettype none

module hs_divider
  import pll_div_pkg::*;
#(
  parameter int unsigned W = HS_W
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Divider stage.
  div_stage_if.stage stg
);

  localparam int unsigned CW = W + 1;

  typedef struct packed {
    logic [CW-1:0] count;
    logic [CW-1:0] term;
    logic          tick;
  } hs_state_s;

  hs_state_s cur;
  hs_state_s next_cur;

  // The code is taken only at a wrap, so a rewrite never cuts a period short.
  always_comb begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (stg.tick_in) begin
      if (cur.count >= cur.term) begin
        next_cur.count = '0;
        next_cur.term  = CW'(stg.value) + CW'(HS_TERM_MIN);
        next_cur.tick  = 1'b1;
      end else begin
        next_cur.count = CW'(cur.count + 1'b1);
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{count: '0, term: CW'(HS_TERM_MIN), tick: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign stg.tick_out = cur.tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle counter between output ticks, used only by the checks below.
  logic [CW-1:0] gap;
  logic          steady;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gap    <= '0;
      steady <= 1'b0;
    end else if (stg.tick_out) begin
      gap    <= '0;
      steady <= 1'b1;
    end else begin
      gap <= CW'(gap + 1'b1);
      if (!stg.tick_in) begin
        steady <= 1'b0;
      end
    end
  end

  hs_min_gap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    stg.tick_out |=> !stg.tick_out [*3])
    else $error("High-speed divider ratio below four.");

  hs_ratio_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (stg.tick_out && steady) |-> gap == $past(cur.term))
    else $error("High-speed divider period differs from code plus four.");

endmodule // hs_divider

`default_nettype wire

// *** rtl/ls_divider.sv ***
// Low-speed divider stage that divides input ticks by its value plus one.
`timescale 1ns/1ns
`default_nettype none

module ls_divider
  import pll_div_pkg::*;
#(
  parameter int unsigned W = LS_W
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Divider stage.
  div_stage_if.stage stg
);

  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] term;
    logic         tick;
  } ls_state_s;

  ls_state_s cur;
  ls_state_s next_cur;

  // A zero terminal count passes every tick, giving a ratio of one.
  always_comb begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (stg.tick_in) begin
      if (cur.count >= cur.term) begin
        next_cur.count = '0;
        next_cur.term  = stg.value;
        next_cur.tick  = 1'b1;
      end else begin
        next_cur.count = W'(cur.count + 1'b1);
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{count: '0, term: '0, tick: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign stg.tick_out = cur.tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Input ticks seen since the last output tick, used only by the checks below.
  logic [W:0] seen;
  logic       armed;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen  <= '0;
      armed <= 1'b0;
    end else if (stg.tick_out) begin
      seen  <= (W+1)'(stg.tick_in);
      armed <= 1'b1;
    end else if (stg.tick_in) begin
      seen <= (W+1)'(seen + 1'b1);
    end
  end

  ls_pass_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (stg.tick_in && cur.term == '0) |=> stg.tick_out)
    else $error("Zero divider value did not pass the tick.");

  ls_ratio_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (stg.tick_out && armed) |-> seen == (W+1)'($past(cur.term)) + 1'b1)
    else $error("Low-speed divider period differs from value plus one.");

  ls_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !stg.tick_in |=> !stg.tick_out)
    else $error("Low-speed divider ticked without an input tick.");

endmodule // ls_divider

`default_nettype wire

// *** rtl/pll_divider_config.sv ***
// Divider configuration registers and divider chain for the clock multiplier.
//
// Overview of operation
// - Output one divider, 20 bits, zero or odd.
// - Output two divider, 20 bits, zero or odd.
// - Zero output divider value means divide by one.
// - Feedback high-speed divider divides by code plus four.
// - Feedback low-speed divides by value plus one.
// - Feedback low-speed output drives the phase detector.
// - Shared high-speed divider feeds both output dividers.
`timescale 1ns/1ns
`default_nettype none

module pll_divider_config
  import pll_div_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Register port from the serial control decoder.
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Settings held in neighbouring registers.
  input  wire logic [HS_W-1:0]   shared_output_highspeed_div,
  input  wire logic [3:0]        out1_div_high,
  // Divided clock ticks.
  output logic                   output_clock_one,
  output logic                   output_clock_two,
  output logic                   pd_feedback_clock
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  typedef struct packed {
    logic [7:0] out1_mid;
    logic [7:0] out1_low;
    logic [3:0] out2_high;
    logic [7:0] out2_mid;
    logic [7:0] out2_low;
    logic [2:0] fb_hs;
    logic [3:0] fb_ls_high;
    logic [7:0] fb_mid;
    logic [7:0] fb_low;
    logic [7:0] rdata;
  } regs_s;

  regs_s cur;
  regs_s next_cur;

  // Tells whether an offset belongs to this block.
  function automatic logic is_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      ADDR_OUT1_MID, ADDR_OUT1_LOW, ADDR_OUT2_HIGH, ADDR_OUT2_MID,
      ADDR_OUT2_LOW, ADDR_FB_HIGH, ADDR_FB_MID, ADDR_FB_LOW: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Builds the read byte; reserved bits and unknown offsets read as zero.
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input regs_s r);
    logic [7:0] data;
    data = RD_NONE;
    case (addr)
      ADDR_OUT1_MID: begin
        data = r.out1_mid;
      end
      ADDR_OUT1_LOW: begin
        data = r.out1_low;
      end
      ADDR_OUT2_HIGH: begin
        data = {4'h0, r.out2_high};
      end
      ADDR_OUT2_MID: begin
        data = r.out2_mid;
      end
      ADDR_OUT2_LOW: begin
        data = r.out2_low;
      end
      ADDR_FB_HIGH: begin
        data = {r.fb_hs, 1'b0, r.fb_ls_high};
      end
      ADDR_FB_MID: begin
        data = r.fb_mid;
      end
      ADDR_FB_LOW: begin
        data = r.fb_low;
      end
      default: begin
        data = RD_NONE;
      end
    endcase
    return data;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and reads.

  // Writes land at the edge; a read in the same cycle returns the old byte.
  always_comb begin
    next_cur = cur;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_OUT1_MID: begin
          next_cur.out1_mid = reg_wdata;
        end
        ADDR_OUT1_LOW: begin
          next_cur.out1_low = reg_wdata;
        end
        ADDR_OUT2_HIGH: begin
          next_cur.out2_high = reg_wdata[LS_TOP_MSB:0];
        end
        ADDR_OUT2_MID: begin
          next_cur.out2_mid = reg_wdata;
        end
        ADDR_OUT2_LOW: begin
          next_cur.out2_low = reg_wdata;
        end
        ADDR_FB_HIGH: begin
          next_cur.fb_hs      = reg_wdata[FB_HS_MSB:FB_HS_LSB];
          next_cur.fb_ls_high = reg_wdata[LS_TOP_MSB:0];
        end
        ADDR_FB_MID: begin
          next_cur.fb_mid = reg_wdata;
        end
        ADDR_FB_LOW: begin
          next_cur.fb_low = reg_wdata;
        end
        default: begin
          next_cur.fb_low = cur.fb_low;
        end
      endcase
    end
    if (reg_rd) begin
      next_cur.rdata = read_mux(reg_addr, cur);
    end
  end

  // Register bank with its documented reset contents.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{
        out1_mid:   RST_OUT1_MID,
        out1_low:   RST_OUT1_LOW,
        out2_high:  RST_OUT2_HIGH[LS_TOP_MSB:0],
        out2_mid:   RST_OUT2_MID,
        out2_low:   RST_OUT2_LOW,
        fb_hs:      RST_FB_HIGH[FB_HS_MSB:FB_HS_LSB],
        fb_ls_high: RST_FB_HIGH[LS_TOP_MSB:0],
        fb_mid:     RST_FB_MID,
        fb_low:     RST_FB_LOW,
        rdata:      RD_NONE
      };
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Divider chain.
  // Each system clock cycle stands for one oscillator cycle at the chain's head.

  div_stage_if #(.W(HS_W)) shared_hs_if ();
  div_stage_if #(.W(HS_W)) fb_hs_if ();
  div_stage_if #(.W(LS_W)) fb_ls_if ();
  div_stage_if #(.W(LS_W)) out_if [2] ();

  // Shared output high-speed stage.
  assign shared_hs_if.value   = shared_output_highspeed_div;
  assign shared_hs_if.tick_in = 1'b1;

  hs_divider #(.W(HS_W)) u_shared_hs (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .stg     (shared_hs_if)
  );

  // Output divider settings, upper output one bits come from outside.
  assign out_if[0].value = {out1_div_high, cur.out1_mid, cur.out1_low};
  assign out_if[1].value = {cur.out2_high, cur.out2_mid, cur.out2_low};

  // Both output low-speed stages count the shared high-speed ticks.
  for (genvar g = 0; g < 2; g++) begin : g_out
    assign out_if[g].tick_in = shared_hs_if.tick_out;

    ls_divider #(.W(LS_W)) u_out_ls (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .stg     (out_if[g])
    );
  end

  assign output_clock_one = out_if[0].tick_out;
  assign output_clock_two = out_if[1].tick_out;

  // Feedback high-speed stage followed by the feedback low-speed stage.
  assign fb_hs_if.value   = cur.fb_hs;
  assign fb_hs_if.tick_in = 1'b1;

  hs_divider #(.W(HS_W)) u_fb_hs (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .stg     (fb_hs_if)
  );

  assign fb_ls_if.value   = {cur.fb_ls_high, cur.fb_mid, cur.fb_low};
  assign fb_ls_if.tick_in = fb_hs_if.tick_out;

  ls_divider #(.W(LS_W)) u_fb_ls (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .stg     (fb_ls_if)
  );

  // The phase detector compares this tick with the divided reference.
  assign pd_feedback_clock = fb_ls_if.tick_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence wr_then_rd(logic [7:0] a);
    (reg_wr && reg_addr == a) ##1 (reg_rd && !reg_wr && reg_addr == a);
  endsequence

  rd_back_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    wr_then_rd(ADDR_OUT1_LOW) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Output one divider byte did not read back.");

  out2_back_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    wr_then_rd(ADDR_OUT2_MID) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Output two divider byte did not read back.");

  fb_back_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    wr_then_rd(ADDR_FB_HIGH) |=> reg_rdata == ($past(reg_wdata, 2) & 8'hEF))
    else $error("Feedback upper byte did not read back with bit four clear.");

  rsvd_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_OUT2_HIGH) |=> reg_rdata[7:4] == 4'h0)
    else $error("Reserved bits of output two upper byte read nonzero.");

  unmapped_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (reg_rd && !is_mapped(reg_addr)) |=> reg_rdata == RD_NONE)
    else $error("Unmapped offset read nonzero.");

  fb_chain_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    pd_feedback_clock |-> $past(fb_hs_if.tick_out))
    else $error("Feedback tick without a feedback high-speed tick.");

  out_chain_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (output_clock_one || output_clock_two) |-> $past(shared_hs_if.tick_out))
    else $error("Output tick without a shared high-speed tick.");

  reset_val_a: assert property (
    @(posedge clk_sys)
    $rose(rst_b) |-> (cur.fb_low == RST_FB_LOW
                      && cur.fb_hs == RST_FB_HIGH[FB_HS_MSB:FB_HS_LSB]
                      && cur.out1_low == RST_OUT1_LOW))
    else $error("Divider registers left reset with wrong values.");

  // A write lands at its own edge, so the next cycle holds the new byte.
  wr_land_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_FB_LOW) |=> cur.fb_low == $past(reg_wdata))
    else $error("Feedback low byte write did not land.");

  // The read byte stands until the next read strobe replaces it.
  rdata_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read byte changed without a read strobe.");

  // Feedback ticks are single-cycle pulses at least four cycles apart.
  fb_pulse_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    pd_feedback_clock |=> !pd_feedback_clock [*3])
    else $error("Feedback tick closer than four cycles.");

  // Output one ticks are spaced by at least four cycles, the shortest shared high-speed period.
  out_pulse_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    output_clock_one |=> !output_clock_one [*3])
    else $error("Output one tick closer than four cycles.");

endmodule // pll_divider_config

`default_nettype wire

// *** tb/host_port_model.sv ***
// Host model that programs the divider registers over the byte-wide register port.
`timescale 1ns/1ns
`default_nettype none

module host_port_model
  import pll_div_pkg::*;
(
  // Clock.
  input  wire logic       clk_sys,
  // Register port.
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////////////////////
  // The port starts idle with both strobes low.
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Released lines show the inverse of their last value so stale data never looks valid.
  task automatic release_bus();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // One write strobe, raised at a falling edge and held across one rising edge.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    release_bus();
  endtask

  // One read strobe; the byte is taken after the rising edge that accepted it.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    data = reg_rdata;
    release_bus();
  endtask

  // A write followed at the very next edge by a read of the same offset.
  task automatic write_read(input logic [7:0] addr, input logic [7:0] data,
                            output logic [7:0] rdata);
    @(negedge clk_sys);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    rdata = reg_rdata;
    release_bus();
  endtask

  // Output dividers take only zero or odd values; bits 19:16 of output one live elsewhere.
  task automatic prog_out(input int n, input logic [19:0] val);
    if (val != 20'h00000 && !val[0]) begin
      $display("host skipped even output divider value");
    end else if (n == 1) begin
      write_reg(ADDR_OUT1_MID, val[15:8]);
      write_reg(ADDR_OUT1_LOW, val[7:0]);
    end else begin
      write_reg(ADDR_OUT2_HIGH, {4'h0, val[19:16]});
      write_reg(ADDR_OUT2_MID, val[15:8]);
      write_reg(ADDR_OUT2_LOW, val[7:0]);
    end
  endtask

  // The feedback low-speed value must be odd so that the ratio is even.
  task automatic prog_fb(input logic [2:0] code, input logic [19:0] val);
    if (!val[0]) begin
      $display("host skipped even feedback divider value");
    end else begin
      write_reg(ADDR_FB_HIGH, {code, 1'b0, val[19:16]});
      write_reg(ADDR_FB_MID, val[15:8]);
      write_reg(ADDR_FB_LOW, val[7:0]);
    end
  endtask
endmodule // host_port_model

`default_nettype wire

// *** tb/pll_divider_config_tb.sv ***
// Self-checking testbench for the divider configuration block.
`timescale 1ns/1ns
`default_nettype none

module pll_divider_config_tb;
  import pll_div_pkg::*;

  logic            clk_sys;
  logic            rst_b;
  logic [7:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [7:0]      reg_rdata;
  logic [HS_W-1:0] shared_hs;
  logic [3:0]      out1_hi;
  logic            output_clock_one;
  logic            output_clock_two;
  logic            pd_feedback_clock;
  logic [7:0]      rd;
  int              fails;
  int              n_compared;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  host_port_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  pll_divider_config dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .shared_output_highspeed_div(shared_hs), .out1_div_high(out1_hi),
    .output_clock_one(output_clock_one), .output_clock_two(output_clock_two),
    .pd_feedback_clock(pd_feedback_clock));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and helpers.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp, input string name);
    host.read_reg(addr, rd);
    check(name, {24'h0, exp}, {24'h0, rd});
  endtask

  // Write and read back at consecutive edges, so the read sees the fresh byte.
  task automatic wr_rd_check(input logic [7:0] addr, input logic [7:0] data,
                             input logic [7:0] exp, input string name);
    host.write_read(addr, data, rd);
    check(name, {24'h0, exp}, {24'h0, rd});
  endtask

  function automatic logic pick(input int sel);
    return (sel == 0) ? output_clock_one : (sel == 1) ? output_clock_two : pd_feedback_clock;
  endfunction

  // Skips two ticks so new settings have landed, then measures the next tick spacing.
  task automatic period(input int sel, input int exp, input string name);
    int n;
    int t;
    int last;
    n = 0;
    t = 0;
    last = 0;
    while (n < 3 && t < 8000) begin
      @(negedge clk_sys);
      t++;
      if (pick(sel) === 1'b1) begin
        n++;
        if (n == 3) check(name, exp, t - last);
        last = t;
      end
    end
    if (n < 3) check(name, exp, 0);
  endtask

  // A hang is cut short well after the expected run length.
  initial begin
    repeat (80000) @(posedge clk_sys);
    fails++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int k;
    int n;
    rst_b      = 1'b0;
    shared_hs  = 3'h0;
    out1_hi    = 4'h0;
    fails      = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;

    // Reset contents, reserved bits and an unmapped offset.
    rd_check(ADDR_OUT1_MID, RST_OUT1_MID, "out1_div_mid");
    rd_check(ADDR_OUT1_LOW, RST_OUT1_LOW, "out1_div_low");
    rd_check(ADDR_OUT2_HIGH, RST_OUT2_HIGH, "out2_div_high");
    rd_check(ADDR_OUT2_MID, RST_OUT2_MID, "out2_div_mid");
    rd_check(ADDR_OUT2_LOW, RST_OUT2_LOW, "out2_div_low");
    rd_check(ADDR_FB_HIGH, RST_FB_HIGH, "feedback_div_high");
    rd_check(ADDR_FB_MID, RST_FB_MID, "feedback_div_mid");
    rd_check(ADDR_FB_LOW, RST_FB_LOW, "feedback_div_low");
    host.write_reg(8'h25, 8'h5A);
    rd_check(8'h25, RD_NONE, "unmapped");
    host.write_reg(ADDR_OUT2_HIGH, 8'hF0);
    rd_check(ADDR_OUT2_HIGH, 8'h00, "out2 reserved");
    wr_rd_check(ADDR_FB_HIGH, 8'hD0, 8'hC0, "feedback reserved");
    wr_rd_check(ADDR_OUT1_LOW, RST_OUT1_LOW, RST_OUT1_LOW, "out1 low back");
    $display("test registers done");

    // Reset settings: feedback ratio 10 times 250, outputs 4 times 50.
    period(2, 2500, "default feedback");
    period(0, 200, "default out1");
    period(1, 200, "default out2");
    $display("test defaults done");

    // Every feedback high-speed code with the smallest feedback ratio.
    for (k = 0; k < 8; k++) begin
      host.prog_fb(k[2:0], 20'h00001);
      period(2, (k + 4) * 2, "feedback code");
    end
    host.prog_fb(3'h7, 20'h00003);
    period(2, 44, "feedback ratio 4");
    rd_check(ADDR_FB_HIGH, 8'hE0, "feedback high");
    rd_check(ADDR_FB_LOW, 8'h03, "feedback low");
    $display("test feedback done");

    // Zero output values follow every shared high-speed code undivided.
    host.prog_out(1, 20'h00000);
    host.prog_out(2, 20'h00000);
    for (k = 0; k < 8; k++) begin
      @(negedge clk_sys) shared_hs = k[2:0];
      period(0, k + 4, "out1 bypass");
      period(1, k + 4, "out2 bypass");
    end
    $display("test bypass done");

    // Odd values spanning the mid and low bytes.
    @(negedge clk_sys) shared_hs = 3'h2;
    host.prog_out(1, 20'h00105);
    period(0, 262 * 6, "out1 ratio");
    host.prog_out(2, 20'h00103);
    period(1, 260 * 6, "out2 ratio");
    wr_rd_check(ADDR_OUT2_MID, 8'h01, 8'h01, "out2 mid");
    $display("test output ratios done");

    // Bit 16 of output one stretches the period far beyond the window watched.
    @(negedge clk_sys) out1_hi = 4'h1;
    // The first tick watched must come from a wrap that already saw the new bits.
    @(negedge clk_sys);
    n = 0;
    while (output_clock_one !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    check("out1 wrap seen", 1, output_clock_one);
    n = 0;
    repeat (3000) begin
      @(negedge clk_sys);
      if (output_clock_one === 1'b1) n++;
    end
    check("out1 upper bits", 0, n);
    $display("test upper bits done");
    summarize();
  end
endmodule // pll_divider_config_tb

`default_nettype wire
